// ===== dv/gil_board.sv
// Purpose: board side of the pads, holding a level on each line
// Assumes: board level is overridden wherever the block drives the pad
// Notes:   a driven pad reads back its own value
`timescale 1ns/1ps
`default_nettype none
module gil_board #(
  parameter int N = 4
) (
  // levels
  input  wire logic [N-1:0] ext_lvl,
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  output logic [N-1:0]      pad_in
);
  // wire level from both parties
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: register level test of status latching, pwm and pad isolation
// Assumes: axi4-lite master tasks, board model on the pads
// Notes:   pwm high time is counted over whole periods
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gil_pkg::*;
  logic        aclk, awready, wready, bvalid, arready, rvalid, irq, wake;
  logic        aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, platform_reset_n = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0]  wstrb = 4'hF, ext_lvl = 0, own = 0, pad_in, pad_out, pad_oe;
  logic [1:0]  bresp, rresp, rs;
  int          error_cnt = 0, checks_done = 0, hi;

  ////////////////////////////////////////////////////////////////////////
  // design and board
  gil_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .platform_reset_n(platform_reset_n), .management_engine_own(own), .irq(irq), .wake(wake));
  gil_board u_brd (.ext_lvl(ext_lvl), .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in));

  // 40 MHz clock
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // report and compare
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) fail($sformatf("seen %h expected %h", seen, exp));
  endtask

  // bus write, waits for the response
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rs = bresp;
        bready <= 1'b0;
        return;
      end
    end
    fail("write timeout");
    summarize();
  endtask

  // bus read into rd and rs
  task automatic rdr(input logic [11:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        return;
      end
    end
    fail("read timeout");
    summarize();
  endtask

  // bounded wait on irq or wake, cycles waited in hi
  task automatic wait_for(input int n, input bit w);
    hi = 0;
    while ((w ? wake : irq) !== 1'b1) begin
      if (hi == n) begin
        fail("wait timeout");
        summarize();
      end
      @(posedge aclk);
      hi++;
    end
  endtask

  // count pwm high cycles on pad 0
  task automatic hcount(input int n);
    hi = 0;
    repeat (n) begin
      @(posedge aclk);
      if (pad_out[0] === 1'b1) hi++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // pad defaults and unmapped access
    rdr(12'h100);
    chk(rd, 32'h0000_0300);
    rdr(12'h10C);
    chk(rd, 32'h0000_0700);
    rdr(12'h0FC);
    chk({rd[31:2], rs}, {30'h0, RESP_SLVERR});
    wr(12'h0FC, 32'h1);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 4; i++) wr(12'(12'h100 + 4 * i), 32'h0000_0100);
    wr(OFS_MASK, 32'h0000_000F);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    // short pulse is latched and held
    ext_lvl <= 4'h4;
    wait_for(30, 0);
    ext_lvl <= 4'h0;
    repeat (20) @(posedge aclk);
    rdr(OFS_STS);
    chk(rd, 32'h4);
    rdr(OFS_STS);
    chk(rd, 32'h0);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    // level still active after clear
    ext_lvl <= 4'h4;
    wait_for(30, 0);
    rdr(OFS_STS);
    rdr(OFS_STS);
    chk(rd, 32'h4);
    ext_lvl <= 4'h0;
    repeat (20) @(posedge aclk);
    rdr(OFS_NMI);
    rdr(OFS_STS);
    // inverted pad 0, nmi unaffected, then masked
    wr(OFS_INV, 32'h1);
    wait_for(30, 0);
    rdr(OFS_NMI);
    chk(rd, 32'h0);
    wr(OFS_MASK, 32'h0);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_INV, 32'h0);
    repeat (20) @(posedge aclk);
    rdr(OFS_STS);
    // deep sleep: slow sampling, primary pads raise no wake
    wr(12'h104, 32'h0000_0300);
    wr(OFS_CTRL, 32'h3);
    ext_lvl <= 4'h5;
    wait_for(5000, 1);
    chk({31'h0, hi > 1000}, 32'h1);
    rdr(OFS_WAKE);
    chk(rd, 32'h4);
    ext_lvl <= 4'h0;
    wr(OFS_CTRL, 32'h0);
    wr(12'h104, 32'h0000_0100);
    // owned pad ignores host writes
    own <= 4'h2;
    wr(12'h104, 32'h0);
    rdr(12'h104);
    chk(rd, 32'h0000_0100);
    own <= 4'h0;
    // platform reset on selected pads only
    wr(12'h100, 32'h0000_2001);
    wr(12'h108, 32'h0000_2500);
    repeat (2) @(posedge aclk);
    chk({31'h0, pad_oe[0] & pad_out[0]}, 32'h1);
    platform_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    platform_reset_n <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, pad_oe[0]}, 32'h0);
    rdr(12'h100);
    chk(rd, 32'h0000_0300);
    rdr(12'h108);
    chk(rd, 32'h0000_0300);
    rdr(12'h104);
    chk(rd, 32'h0000_0100);
    rdr(12'h10C);
    chk(rd, 32'h0000_0100);
    // pwm first activation, four strobes per period, half duty
    wr(12'h100, 32'h0000_1000);
    wr(12'h200, 32'h4040_0080);
    wr(12'h200, 32'h8040_0080);
    repeat (4880) @(posedge aclk);
    hcount(9760);
    chk(hi, 4880);
    // running update, staged until next period
    wr(12'h200, 32'hC040_0040);
    rdr(12'h200);
    chk(rd, 32'hC040_0040);
    repeat (4880) @(posedge aclk);
    rdr(12'h200);
    chk(rd, 32'h8040_0040);
    hcount(9760);
    chk(hi, 7320);
    summarize();
  end
endmodule
`default_nettype wire

// ===== rtl/gil_latch.sv
// Purpose: sticky input status for a vector of sampled inputs
// Assumes: act is already polarity corrected and gated
// Notes:   a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none
module gil_latch #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // sampling
  input  wire logic         tick,
  input  wire logic [W-1:0] act,
  input  wire logic [W-1:0] clr,
  // status
  output logic [W-1:0]      sts
);
  import gil_pkg::*;

  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] sts;
  } gil_lat_t;

  gil_lat_t     r;
  gil_lat_t     next_r;
  logic [W-1:0] set;

  // two consecutive active samples set the bit
  always_comb begin
    next_r = r;
    set = tick ? (act & r.prev) : '0;                    // RULE_07
    if (tick) begin
      next_r.prev = act;
    end
    next_r.sts = (r.sts & ~clr) | set;                   // RULE_11
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sts = r.sts;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_two_samples: assert property (tick |=> (r.sts & $past(act & r.prev)) == $past(act & r.prev)) // RULE_07
    else $error("status not set after two active samples");
  a_sticky_hold: assert property (1'b1 |=> ($past(r.sts & ~clr) & ~r.sts) == '0) // RULE_07
    else $error("status dropped without a clear");
  a_relatch: assert property (tick && |(act & r.prev & clr) |=> |(r.sts & $past(act & r.prev & clr))) // RULE_11
    else $error("active input lost on clear");
endmodule
`default_nettype wire

// ===== rtl/gil_pwm.sv
// Purpose: one blink/pwm channel with staged settings
// Assumes: tick is a one-cycle pwm clock strobe
// Notes:   step is 8.8 fixed point added into the upper accumulator bits
`timescale 1ns/1ps
`default_nettype none
module gil_pwm (
  // clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // settings
  input  wire logic                       tick,
  input  wire logic                       en,
  input  wire logic [gil_pkg::STEP_W-1:0] step,
  input  wire logic [gil_pkg::THR_W-1:0]  thr,
  input  wire logic                       commit,
  // state
  output logic                            pend,
  output logic                            out
);
  import gil_pkg::*;

  typedef struct packed {
    logic [ACC_W-1:0]  acc;
    logic [STEP_W-1:0] step;
    logic [THR_W-1:0]  thr;
    logic              pend;
    logic              out;
  } gil_pwm_t;

  gil_pwm_t        r;
  gil_pwm_t        next_r;
  logic [ACC_W:0]  sum;

  // accumulate, wrap, compare, apply staged settings
  always_comb begin
    next_r = r;
    sum = {1'b0, r.acc} + {1'b0, r.step, 8'h00};       // RULE_03
    next_r.pend = r.pend | commit;
    if (!en) begin
      next_r.acc = '0;
      next_r.out = 1'b0;
      if (r.pend) begin
        next_r.step = step;
        next_r.thr  = thr;
        next_r.pend = commit;
      end
    end else if (tick) begin
      next_r.acc = sum[ACC_W-1:0];
      if (sum[ACC_W]) begin
        next_r.out = 1'b0;                               // RULE_04
        if (r.pend) begin
          next_r.step = step;                            // RULE_05
          next_r.thr  = thr;
          next_r.pend = commit;
        end
      end else begin
        next_r.out = (r.step != '0) && (sum[ACC_W-1:ACC_W-8] >= r.thr); // RULE_04 RULE_06
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pend = r.pend;
  assign out  = r.out;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_acc_hold: assert property (en && !tick |=> r.acc == $past(r.acc)) // RULE_03
    else $error("accumulator moved without a pwm tick");
  a_wrap_low: assert property (en && tick && sum[ACC_W] |=> !r.out) // RULE_04
    else $error("period did not begin low");
  a_high_cmp: assert property (en && tick && !sum[ACC_W] && r.step != '0 && sum[23:16] >= r.thr |=> r.out) // RULE_06
    else $error("output not high at threshold");
  a_commit_apply: assert property (en && tick && sum[ACC_W] && r.pend && !commit
                                   |=> !r.pend && r.thr == $past(thr)) // RULE_05
    else $error("staged settings not applied at wrap");
  a_commit_wait: assert property (en && r.pend && !(tick && sum[ACC_W]) |=> r.pend) // RULE_05
    else $error("commit cleared before period start");
endmodule
`default_nettype wire

// ===== rtl/gil_top.sv
// Purpose: gpio pads with sticky input status, pwm outputs and sleep isolation
// Assumes: aclk 40 MHz, axi4-lite slave, one write and one read in flight
// Notes:   pad and platform reset pins pass two flops before use
//
// Function
// [RULE_01] firmware first writes step and threshold, commits, then enables pwm
// [RULE_02] firmware changes running pwm by writing settings then commit only
// [RULE_03] each pwm clock adds step to 24-bit accumulator; overflow starts period
// [RULE_04] period starts low, goes high at threshold, stays high until overflow
// [RULE_05] committed settings apply at next period start; commit bit self-clears
// [RULE_06] threshold compares against the top eight accumulator bits
// [RULE_07] input active two consecutive samples sets sticky status until cleared
// [RULE_08] polarity invert selects active level; nmi status ignores it
// [RULE_09] working state samples inputs at 12 MHz; code strobes every 3 aclk cycles, 13.33 MHz
// [RULE_10] sleep states sample inputs at 32.768 kHz; code strobes every 1220 aclk cycles, 32.79 kHz
// [RULE_11] input still active after clear sets status again
// [RULE_12] primary domain inputs raise no wake in deep sleep
// [RULE_13] selected platform reset forces receive disable to one, fields to default
// [RULE_14] selected platform reset forces transmit disable to one
// [RULE_15] selected platform reset returns a gpio-default pad to gpio mode
// [RULE_16] firmware may disable paths and pull-ups before sleep, restore after
// [RULE_17] firmware leaves reset select at default on native-default pads
// [RULE_18] pads owned by management engine ignore host writes
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module gil_top #(
  parameter int              NPAD       = 4,
  parameter int              NPWM       = 2,
  parameter logic [NPAD-1:0] PRIMARY    = 4'h3,
  parameter logic [NPAD-1:0] NATIVE_DEF = 4'h8
) (
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // axi4-lite write address and data
  input  wire logic [11:0]     awaddr,
  input  wire logic            awvalid,
  output logic                 awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output logic                 wready,
  // axi4-lite write response
  output logic [1:0]           bresp,
  output logic                 bvalid,
  input  wire logic            bready,
  // axi4-lite read
  input  wire logic [11:0]     araddr,
  input  wire logic            arvalid,
  output logic                 arready,
  output logic [31:0]          rdata,
  output logic [1:0]           rresp,
  output logic                 rvalid,
  input  wire logic            rready,
  // pads and system
  input  wire logic [NPAD-1:0] pad_in,
  output logic [NPAD-1:0]      pad_out,
  output logic [NPAD-1:0]      pad_oe,
  input  wire logic            platform_reset_n,
  input  wire logic [NPAD-1:0] management_engine_own,
  // events
  output logic                 irq,
  output logic                 wake
);
  import gil_pkg::*;

  ////////////////////////////////////////////////////////////
  // state and signals

  typedef struct packed {
    logic                         awready;
    logic                         wready;
    logic                         bvalid;
    logic                         arready;
    logic                         rvalid;
    logic [1:0]                   bresp;
    logic [1:0]                   rresp;
    logic [31:0]                  rdata;
    logic                         aw_h;
    logic                         w_h;
    logic [11:0]                  wa;
    logic [31:0]                  wd;
    logic [3:0]                   ws;
    logic [NPAD-1:0]              s1;
    logic [NPAD-1:0]              s2;
    logic [NPAD-1:0]              inv;
    logic [NPAD-1:0]              mask;
    logic [NPAD-1:0]              txd;
    logic [NPAD-1:0]              txdis;
    logic [NPAD-1:0]              rxdis;
    logic [NPAD-1:0]              rsel;
    logic [NPAD-1:0][2:0]         mode;
    logic [NPAD-1:0][1:0]         term;
    logic                         plt1;
    logic                         plt2;
    logic                         sleep;
    logic                         deep;
    logic [NPWM-1:0][STEP_W-1:0]  step;
    logic [NPWM-1:0][THR_W-1:0]   thr;
    logic [NPWM-1:0]              pen;
    logic [NPWM-1:0]              pcom;
    logic [CNT_W-1:0]             scnt;
    logic [CNT_W-1:0]             pcnt;
    logic                         stick;
    logic                         ptick;
    logic                         irq;
    logic                         wake;
    logic [NPAD-1:0]              pout;
    logic [NPAD-1:0]              poe;
  } gil_st_t;

  gil_st_t         r;
  gil_st_t         next_r;
  logic [NPAD-1:0] sts;
  logic [NPAD-1:0] nmi;
  logic [NPAD-1:0] sclr;
  logic [NPAD-1:0] nclr;
  logic [NPAD-1:0] act;
  logic [NPAD-1:0] raw;
  logic [NPAD-1:0] pw;
  logic [NPAD-1:0] pw_cap;
  logic [NPAD-1:0] prst;
  logic [NPWM-1:0] pend;
  logic [NPWM-1:0] pwm_o;
  logic            wr_fire;
  logic            own_blk;
  logic [32:0]     wold;
  logic [32:0]     rd;
  logic [31:0]     wv;
  int unsigned     wk;

  // default mode per pad after reset
  function automatic logic [NPAD-1:0][2:0] mode_dflt();
    logic [NPAD-1:0][2:0] m;
    for (int i = 0; i < NPAD; i++) begin
      m[i] = NATIVE_DEF[i] ? MODE_NAT1 : MODE_GPIO;
    end
    return m;
  endfunction

  localparam logic [NPAD-1:0][2:0] MODE_RST = mode_dflt();

  // byte-lane merge of a write into the current value
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{s[b]}};
    end
    return (o & ~m) | (d & m);
  endfunction

  // read mux; top bit marks a mapped address
  function automatic logic [32:0] rdmux(input logic [11:0] a);
    logic [32:0] v;
    int unsigned k;
    v = {1'b1, 32'h0};
    k = 32'(a[7:2]);
    if (a == OFS_CTRL) begin
      v[1:0] = {r.deep, r.sleep};
    end else if (a == OFS_INV) begin
      v[NPAD-1:0] = r.inv;
    end else if (a == OFS_STS) begin
      v[NPAD-1:0] = sts;
    end else if (a == OFS_MASK) begin
      v[NPAD-1:0] = r.mask;
    end else if (a == OFS_NMI) begin
      v[NPAD-1:0] = nmi;
    end else if (a == OFS_WAKE) begin
      v[NPAD-1:0] = sts & ~(r.deep ? PRIMARY : '0);
    end else if (a == OFS_OWN) begin
      v[NPAD-1:0] = management_engine_own;
    end else if (a[11:8] == PG_PAD && a[1:0] == 2'h0 && k < NPAD) begin
      v[15:0] = {r.term[k], r.rsel[k], r.mode[k], r.rxdis[k], r.txdis[k], 6'h00,
                 r.s2[k] & ~r.rxdis[k], r.txd[k]};
    end else if (a[11:8] == PG_PWM && a[1:0] == 2'h0 && k < NPWM) begin
      v[31:0] = {r.pen[k], pend[k], 6'h00, r.step[k], r.thr[k]};
    end else begin
      v = 33'h0;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    sclr = '0;
    nclr = '0;
    own_blk = 1'b0;
    next_r.pcom = '0;
    // pin synchronisers
    next_r.s1 = pad_in;
    next_r.s2 = r.s1;
    next_r.plt1 = platform_reset_n;
    next_r.plt2 = r.plt1;
    // sample strobe, rate follows power state
    next_r.stick = (r.scnt == '0);
    next_r.scnt = r.scnt - 11'h001;
    if (r.scnt == '0) begin
      next_r.scnt = r.sleep ? SLOW_RLD : FAST_RLD;  // RULE_09 RULE_10
    end
    // pwm clock strobe
    next_r.ptick = (r.pcnt == '0);
    next_r.pcnt = (r.pcnt == '0) ? PWM_RLD : r.pcnt - 11'h001;
    // write channel capture
    if (awvalid && r.awready) begin
      next_r.aw_h = 1'b1;
      next_r.wa = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.w_h = 1'b1;
      next_r.wd = wdata;
      next_r.ws = wstrb;
    end
    // write execute once both halves are held
    wr_fire = r.aw_h && r.w_h && !r.bvalid;
    wold = rdmux(r.wa);
    wv = merge(wold[31:0], r.wd, r.ws);
    wk = 32'(r.wa[7:2]);
    if (wr_fire) begin
      next_r.aw_h = 1'b0;
      next_r.w_h = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = wold[32] ? RESP_OKAY : RESP_SLVERR;
      if (r.wa == OFS_CTRL) begin
        next_r.sleep = wv[CTRL_SLEEP];
        next_r.deep = wv[CTRL_DEEP];
      end else if (r.wa == OFS_INV) begin
        next_r.inv = wv[NPAD-1:0];
      end else if (r.wa == OFS_MASK) begin
        next_r.mask = wv[NPAD-1:0];
      end else if (wold[32] && r.wa[11:8] == PG_PAD) begin
        if (management_engine_own[wk]) begin
          own_blk = 1'b1;                                // RULE_18
        end else begin
          next_r.txd[wk] = wv[CFG_TXD];
          next_r.txdis[wk] = wv[CFG_TXDIS];
          next_r.rxdis[wk] = wv[CFG_RXDIS];
          next_r.mode[wk] = wv[CFG_MODE +: 3];
          next_r.rsel[wk] = wv[CFG_RSEL];
          next_r.term[wk] = wv[CFG_TERM +: 2];
        end
      end else if (wold[32] && r.wa[11:8] == PG_PWM) begin
        next_r.thr[wk] = wv[PWM_THR +: THR_W];
        next_r.step[wk] = wv[PWM_STEP +: STEP_W];
        next_r.pen[wk] = wv[PWM_EN];
        next_r.pcom[wk] = r.ws[3] && r.wd[PWM_COMMIT];
      end
    end else if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    // read channel; status reads clear
    rd = rdmux(araddr);
    if (arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd[31:0];
      next_r.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      sclr = (araddr == OFS_STS) ? '1 : '0;
      nclr = (araddr == OFS_NMI) ? '1 : '0;
    end else if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    next_r.awready = !next_r.aw_h && !next_r.bvalid;
    next_r.wready = !next_r.w_h && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
    // platform reset on selected pads wins over a host write
    next_r.txdis = next_r.txdis | prst;                  // RULE_14
    next_r.rxdis = next_r.rxdis | prst;                  // RULE_13
    next_r.txd = next_r.txd & ~prst;
    next_r.rsel = next_r.rsel & ~prst;
    for (int i = 0; i < NPAD; i++) begin
      if (prst[i]) begin
        next_r.mode[i] = MODE_RST[i];                    // RULE_15
        next_r.term[i] = 2'h0;                           // RULE_13
      end
    end
    // interrupt and wake, deep sleep drops primary pads from wake
    next_r.irq = |(sts & r.mask);
    next_r.wake = r.sleep && |(sts & ~(r.deep ? PRIMARY : '0)); // RULE_12
    // pad drive
    for (int i = 0; i < NPAD; i++) begin
      next_r.pout[i] = (r.mode[i] == MODE_PWM) ? pw[i] : r.txd[i];
      next_r.poe[i] = !r.txdis[i] && (r.mode[i] == MODE_GPIO || (r.mode[i] == MODE_PWM && pw_cap[i])); // RULE_14
    end
  end

  // inputs seen by the latches
  assign prst = {NPAD{!r.plt2}} & r.rsel;
  assign act  = ~r.rxdis & (r.s2 ^ r.inv);                // RULE_08
  assign raw  = ~r.rxdis & r.s2;                          // RULE_08

  ////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.txdis <= '1;
      r.rxdis <= '1;
      r.mode <= MODE_RST;
      r.plt1 <= 1'b1;
      r.plt2 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////
  // submodules

  // sticky status, polarity applied
  gil_latch #(.W(NPAD)) u_sts (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (r.stick),
    .act     (act),
    .clr     (sclr),
    .sts     (sts)
  );

  // nmi status, raw level
  gil_latch #(.W(NPAD)) u_nmi (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (r.stick),
    .act     (raw),
    .clr     (nclr),
    .sts     (nmi)
  );

  // pwm channels and their pad mapping
  genvar g;
  generate
    for (g = 0; g < NPAD; g++) begin : g_pad
      if (g < NPWM) begin : g_ch
        gil_pwm u_pwm (
          .aclk    (aclk),
          .aresetn (aresetn),
          .tick    (r.ptick),
          .en      (r.pen[g]),
          .step    (r.step[g]),
          .thr     (r.thr[g]),
          .commit  (r.pcom[g]),
          .pend    (pend[g]),
          .out     (pwm_o[g])
        );
        assign pw[g]     = pwm_o[g];
        assign pw_cap[g] = 1'b1;
      end else begin : g_no
        assign pw[g]     = 1'b0;
        assign pw_cap[g] = 1'b0;
      end
    end
  endgenerate

  // outputs from flops
  assign awready = r.awready;
  assign wready  = r.wready;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign arready = r.arready;
  assign rvalid  = r.rvalid;
  assign rdata   = r.rdata;
  assign rresp   = r.rresp;
  assign pad_out = r.pout;
  assign pad_oe  = r.poe;
  assign irq     = r.irq;
  assign wake    = r.wake;

  ////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rx_isolate: assert property (prst != '0 |=> (r.rxdis & $past(prst)) == $past(prst)) // RULE_13
    else $error("receive path not disabled by platform reset");
  a_tx_isolate: assert property (prst != '0 |=> ##1 (r.poe & $past(prst, 2)) == '0) // RULE_14
    else $error("pad still driven after platform reset");
  a_mode_revert: assert property (prst[0] |=> r.mode[0] == MODE_RST[0]) // RULE_15
    else $error("pad mode not returned to default");
  a_owner_block: assert property (own_blk && r.plt2 |=> r.txd == $past(r.txd) && r.mode == $past(r.mode)) // RULE_18
    else $error("host write changed an owned pad");
  a_fast_rate: assert property (r.stick && !$past(r.sleep) |-> r.scnt == FAST_RLD ##3 r.stick) // RULE_09
    else $error("working state sample spacing wrong");
  a_slow_rate: assert property (r.stick && $past(r.sleep) |-> r.scnt == SLOW_RLD) // RULE_10
    else $error("sleep sample spacing wrong");
  a_wake_primary: assert property (r.deep && (sts & ~PRIMARY) == '0 |=> !r.wake) // RULE_12
    else $error("primary pad woke from deep sleep");
  a_irq_level: assert property ((sts & r.mask) != '0 |=> r.irq)
    else $error("unmasked status without interrupt");

  c_irq_rise: cover property (!r.irq ##1 r.irq);
  c_isolate: cover property (prst != '0);
  c_owned_write: cover property (own_blk);
endmodule
`default_nettype wire

// ===== shared/gil_pkg.sv
// Purpose: shared constants of the gpio latch, pwm and pad isolation block
// Assumes: aclk at 40 MHz, registers reached over axi4-lite
// Notes:   offsets are byte addresses, one aligned word per register
package gil_pkg;

  // clock and sampling rates
  localparam int unsigned CLK_HZ       = 40000000;
  localparam int unsigned SAMP_FAST_HZ = 12000000;  // working state
  localparam int unsigned SAMP_SLOW_HZ = 32768;     // sleep states
  localparam int unsigned PWM_CLK_HZ   = 32768;
  localparam int unsigned FAST_CYC     = CLK_HZ / SAMP_FAST_HZ;
  localparam int unsigned SLOW_CYC     = CLK_HZ / SAMP_SLOW_HZ;
  localparam int unsigned PWM_CYC      = CLK_HZ / PWM_CLK_HZ;
  localparam int          CNT_W        = 11;
  localparam logic [10:0] FAST_RLD     = 11'(FAST_CYC - 1);
  localparam logic [10:0] SLOW_RLD     = 11'(SLOW_CYC - 1);
  localparam logic [10:0] PWM_RLD      = 11'(PWM_CYC - 1);

  // pwm widths
  localparam int ACC_W  = 24;
  localparam int STEP_W = 16;
  localparam int THR_W  = 8;

  // register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_INV  = 12'h004;
  localparam logic [11:0] OFS_STS  = 12'h008;
  localparam logic [11:0] OFS_MASK = 12'h00C;
  localparam logic [11:0] OFS_NMI  = 12'h010;
  localparam logic [11:0] OFS_WAKE = 12'h014;
  localparam logic [11:0] OFS_OWN  = 12'h018;
  localparam logic [3:0]  PG_PAD   = 4'h1;    // pad_config_word0 at 0x100 + 4*pad
  localparam logic [3:0]  PG_PWM   = 4'h2;    // pwm_control at 0x200 + 4*channel

  // field positions
  localparam int CTRL_SLEEP = 0;
  localparam int CTRL_DEEP  = 1;
  localparam int CFG_TXD    = 0;
  localparam int CFG_TXDIS  = 8;
  localparam int CFG_RXDIS  = 9;
  localparam int CFG_MODE   = 10;
  localparam int CFG_RSEL   = 13;
  localparam int CFG_TERM   = 14;
  localparam int PWM_THR    = 0;
  localparam int PWM_STEP   = 8;
  localparam int PWM_COMMIT = 30;
  localparam int PWM_EN     = 31;

  // pad modes and bus answers
  localparam logic [2:0] MODE_GPIO   = 3'h0;
  localparam logic [2:0] MODE_NAT1   = 3'h1;
  localparam logic [2:0] MODE_PWM    = 3'h4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
